//--- hw/idasr_pkg.sv
// package: register offsets, field layouts, reset values and carriers of the input divider block
package idasr_pkg;
    localparam int          IDASR_ADDR_W       = 8;
    localparam int          IDASR_DATA_W       = 8;
    localparam int          IDASR_DIV_W        = 19;
    localparam int          IDASR_BAND_W       = 3;
    // register offsets
    localparam logic [7:0]  IDASR_OFS_IN1_HIGH = 8'h2B;
    localparam logic [7:0]  IDASR_OFS_IN1_MID  = 8'h2C;
    localparam logic [7:0]  IDASR_OFS_IN1_LOW  = 8'h2D;
    localparam logic [7:0]  IDASR_OFS_IN2_HIGH = 8'h2E;
    localparam logic [7:0]  IDASR_OFS_IN2_MID  = 8'h2F;
    localparam logic [7:0]  IDASR_OFS_IN2_LOW  = 8'h30;
    localparam logic [7:0]  IDASR_OFS_BAND     = 8'h37;
    localparam logic [7:0]  IDASR_OFS_ACTIVE   = 8'h80;
    localparam logic [7:0]  IDASR_OFS_MISSING  = 8'h81;
    localparam logic [7:0]  IDASR_OFS_STICKY   = 8'h83;
    // field positions
    localparam int          IDASR_BAND1_LSB    = 0;
    localparam int          IDASR_BAND2_LSB    = 3;
    localparam int          IDASR_ACT1_BIT     = 0;
    localparam int          IDASR_ACT2_BIT     = 1;
    localparam int          IDASR_XTAL_BIT     = 0;
    localparam int          IDASR_MISS1_BIT    = 1;
    localparam int          IDASR_MISS2_BIT    = 2;
    // reset values
    localparam logic [18:0] IDASR_IN1_RST      = 19'h00009;
    localparam logic [18:0] IDASR_IN2_RST      = 19'h00000;
    localparam logic [5:0]  IDASR_BAND_RST     = 6'h00;
    localparam logic [7:0]  IDASR_ZERO_BYTE    = 8'h00;

    // one register port access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } idasr_req_t;

    // live alarm levels from the analog monitors
    typedef struct packed {
        logic in2_missing;
        logic in1_missing;
        logic xtal_missing;
    } idasr_alarm_t;
endpackage

//--- hw/idasr_sticky.sv
// sticky alarm flag: set by alarm, cleared by writing zero
`timescale 1ns/1ps
`default_nettype none
module idasr_sticky
    import idasr_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] alarm,
    input  wire logic             clr_wr,
    input  wire logic [WIDTH-1:0] clr_data,
    output var  logic [WIDTH-1:0] flag
);
    // one flop per alarm; the set wins over a same-cycle clear so no event is lost
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    flag[i] <= 1'b0;
                end else if (alarm[i]) begin
                    flag[i] <= 1'b1;
                end else if (clr_wr && !clr_data[i]) begin
                    flag[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- hw/idasr_regs.sv
// register slice: input pre-dividers, band selects, active input and signal loss status
// Functional notes
// - input-1 divider bits 15:0 at 44,45
// - zero code divides by one, up to 2^19
// - input-2 divider 19 bits at 46..48
// - input-2 zero code divides by one
// - band selects in register 55, two fields
// - reg 128 bit 1: input 2 active
// - reg 128 bit 0: input 1 active
// - reg 129 bit 2: input-2 signal loss
// - reg 129 bit 1: input-1 signal loss
// - reg 129 bit 0: reference signal loss
// - input-1 divider bits 18:16 in reg 43
// - sticky loss flags, cleared by writing zero
`timescale 1ns/1ps
`default_nettype none
module idasr_regs
    import idasr_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire idasr_req_t               req,
    input  wire idasr_alarm_t             alarm,
    input  wire logic                     in2_selected,
    output var  logic [IDASR_DATA_W-1:0]  rdata,
    output var  logic                     rvalid,
    output var  logic [IDASR_DIV_W-1:0]   in1_prediv,
    output var  logic [IDASR_DIV_W-1:0]   in2_prediv,
    output var  logic [IDASR_DIV_W:0]     in1_ratio,
    output var  logic [IDASR_DIV_W:0]     in2_ratio,
    output var  logic [IDASR_BAND_W-1:0]  in1_band_sel,
    output var  logic [IDASR_BAND_W-1:0]  in2_band_sel,
    output var  logic                     in1_active,
    output var  logic                     in2_active,
    output var  logic [2:0]               missing_sticky
);
    logic [2:0] alarm_vec;
    logic       sticky_wr;
    logic [2:0] sticky_flag;
    logic [7:0] next_rdata;
    logic       wr_in1_high;
    logic       wr_in1_mid;
    logic       wr_in1_low;
    logic       wr_in2_high;
    logic       wr_in2_mid;
    logic       wr_in2_low;
    logic       wr_band;
    logic [7:0] active_byte;
    logic [7:0] loss_byte;
    logic [7:0] sticky_byte;

    // map of this slice, offsets in hex:
    //   2B  input-1 divider bits 18:16 in 2:0, rest reserved
    //   2C  input-1 divider bits 15:8
    //   2D  input-1 divider bits 7:0
    //   2E  input-2 divider bits 18:16 in 2:0, rest reserved
    //   2F  input-2 divider bits 15:8
    //   30  input-2 divider bits 7:0
    //   37  band selects, input 2 in 5:3, input 1 in 2:0
    //   80  active input flags, read only
    //   81  live signal loss levels, read only
    //   83  sticky loss flags, write zero to clear
    // every other offset reads zero and drops writes
    // read data is registered and shows with rvalid one cycle after the strobe
    // a write and a read in one cycle return the contents before the write
    // a divider has no shadow copy: a multi-byte update passes through
    // mixed codes, so software should rewrite it while the input is idle

    assign alarm_vec = {alarm.in2_missing, alarm.in1_missing, alarm.xtal_missing};

    // one write enable per writable register, decoded once so the storage processes stay simple
    always_comb begin
        wr_in1_high = 1'b0;
        wr_in1_mid  = 1'b0;
        wr_in1_low  = 1'b0;
        wr_in2_high = 1'b0;
        wr_in2_mid  = 1'b0;
        wr_in2_low  = 1'b0;
        wr_band     = 1'b0;
        sticky_wr   = 1'b0;
        if (req.wr) begin
            case (req.addr)
                IDASR_OFS_IN1_HIGH: wr_in1_high = 1'b1;
                IDASR_OFS_IN1_MID:  wr_in1_mid  = 1'b1;
                IDASR_OFS_IN1_LOW:  wr_in1_low  = 1'b1;
                IDASR_OFS_IN2_HIGH: wr_in2_high = 1'b1;
                IDASR_OFS_IN2_MID:  wr_in2_mid  = 1'b1;
                IDASR_OFS_IN2_LOW:  wr_in2_low  = 1'b1;
                IDASR_OFS_BAND:     wr_band     = 1'b1;
                IDASR_OFS_STICKY:   sticky_wr   = 1'b1;
                default: ;
            endcase
        end
    end

    // input-1 divider storage, byte per register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            in1_prediv <= IDASR_IN1_RST;
        end else begin
            if (wr_in1_high) begin
                in1_prediv[18:16] <= req.wdata[2:0];
            end
            if (wr_in1_mid) begin
                in1_prediv[15:8] <= req.wdata;
            end
            if (wr_in1_low) begin
                in1_prediv[7:0] <= req.wdata;
            end
        end
    end

    // input-2 divider storage
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            in2_prediv <= IDASR_IN2_RST;
        end else begin
            if (wr_in2_high) begin
                in2_prediv[18:16] <= req.wdata[2:0];
            end
            if (wr_in2_mid) begin
                in2_prediv[15:8] <= req.wdata;
            end
            if (wr_in2_low) begin
                in2_prediv[7:0] <= req.wdata;
            end
        end
    end

    // ratio is code plus one, so all-zero divides by one and all-ones by 2^19
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            in1_ratio <= {1'b0, IDASR_IN1_RST} + 20'h00001;
            in2_ratio <= {1'b0, IDASR_IN2_RST} + 20'h00001;
        end else begin
            in1_ratio <= {1'b0, in1_prediv} + 20'h00001;
            in2_ratio <= {1'b0, in2_prediv} + 20'h00001;
        end
    end

    // band selects; reserved codes are stored as written, software avoids them
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            {in2_band_sel, in1_band_sel} <= IDASR_BAND_RST;
        end else if (wr_band) begin
            in1_band_sel <= req.wdata[IDASR_BAND1_LSB +: IDASR_BAND_W];
            in2_band_sel <= req.wdata[IDASR_BAND2_LSB +: IDASR_BAND_W];
        end
    end

    // active input: selected and not lost of signal
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            in1_active <= 1'b0;
            in2_active <= 1'b0;
        end else begin
            in2_active <= in2_selected && !alarm.in2_missing;
            in1_active <= !in2_selected && !alarm.in1_missing;
        end
    end

    // sticky flags kept in their own module
    // an alarm still raised while software clears keeps its flag set
    idasr_sticky #(
        .WIDTH   (3)
    ) u_sticky (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .alarm    (alarm_vec),
        .clr_wr   (sticky_wr),
        .clr_data (req.wdata[2:0]),
        .flag     (sticky_flag)
    );
    assign missing_sticky = sticky_flag;

    // status bytes; loss levels pass live, so a read shows the level of that cycle
    always_comb begin
        active_byte = IDASR_ZERO_BYTE;
        loss_byte   = IDASR_ZERO_BYTE;
        sticky_byte = IDASR_ZERO_BYTE;
        active_byte[IDASR_ACT2_BIT] = in2_active;
        active_byte[IDASR_ACT1_BIT] = in1_active;
        loss_byte[IDASR_MISS2_BIT]  = alarm.in2_missing;
        loss_byte[IDASR_MISS1_BIT]  = alarm.in1_missing;
        loss_byte[IDASR_XTAL_BIT]   = alarm.xtal_missing;
        sticky_byte[2:0]            = sticky_flag;
    end

    // read mux; live alarms read straight, reserved bits read zero
    always_comb begin
        next_rdata = IDASR_ZERO_BYTE;
        case (req.addr)
            IDASR_OFS_IN1_HIGH: next_rdata = {5'h00, in1_prediv[18:16]};
            IDASR_OFS_IN1_MID:  next_rdata = in1_prediv[15:8];
            IDASR_OFS_IN1_LOW:  next_rdata = in1_prediv[7:0];
            IDASR_OFS_IN2_HIGH: next_rdata = {5'h00, in2_prediv[18:16]};
            IDASR_OFS_IN2_MID:  next_rdata = in2_prediv[15:8];
            IDASR_OFS_IN2_LOW:  next_rdata = in2_prediv[7:0];
            IDASR_OFS_BAND:     next_rdata = {2'h0, in2_band_sel, in1_band_sel};
            IDASR_OFS_ACTIVE:   next_rdata = active_byte;
            IDASR_OFS_MISSING:  next_rdata = loss_byte;
            IDASR_OFS_STICKY:   next_rdata = sticky_byte;
            default:            next_rdata = IDASR_ZERO_BYTE;
        endcase
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata  <= IDASR_ZERO_BYTE;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rdata <= next_rdata;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/idasr_host.sv
// host model: issues register reads and writes on the request port
`timescale 1ns/1ps
`default_nettype none
module idasr_host
    import idasr_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rvalid,
    input  wire logic [7:0] rdata,
    output var  idasr_req_t req
);
    // idle at time zero
    initial req = '{1'b0, 1'b0, 8'h00, 8'h00};
    // released address and data are inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys) req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    // answer is taken once the taking edge has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys) req <= '{1'b1 ^ 1'b1, 1'b1, a, 8'h00};
        @(posedge clk_sys) req <= '{1'b0, 1'b0, ~a, 8'hFF};
        #1 d = rvalid ? rdata : 8'hXX;
    endtask
endmodule
`default_nettype wire

//--- verification/idasr_regs_properties.sv
// checker: timing properties of the register slice ports
`timescale 1ns/1ps
`default_nettype none
module idasr_props
    import idasr_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         sys_rst,
    input wire idasr_req_t   req,
    input wire idasr_alarm_t alarm,
    input wire logic         in2_selected,
    input wire logic [7:0]   rdata,
    input wire logic         rvalid,
    input wire logic [18:0]  in1_prediv,
    input wire logic [18:0]  in2_prediv,
    input wire logic [19:0]  in1_ratio,
    input wire logic [2:0]   in1_band_sel,
    input wire logic [2:0]   in2_band_sel,
    input wire logic         in1_active,
    input wire logic         in2_active,
    input wire logic [2:0]   missing_sticky
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // write taken at one offset
    sequence s_wr(logic [7:0] a); req.wr && req.addr == a; endsequence
    a_rd_answer: assert property (req.rd |=> rvalid)
        else $error("read not answered");
    a_in1_low_wr: assert property (s_wr(8'h2D) |=>
        in1_prediv[7:0] == $past(req.wdata)) else $error("in1 low byte lost");
    a_in2_top_wr: assert property (s_wr(8'h2E) |=>
        in2_prediv[18:16] == $past(req.wdata[2:0])) else $error("in2 top bits lost");
    a_band_wr: assert property (s_wr(8'h37) |=>
        {in2_band_sel, in1_band_sel} == $past(req.wdata[5:0])) else $error("band lost");
    a_ratio_plus: assert property (in1_ratio == $past(in1_prediv) + 20'h1)
        else $error("ratio not code plus one");
    a_act_two: assert property (!$past(sys_rst) |->
        in2_active == $past(in2_selected && !alarm.in2_missing)) else $error("in2 active");
    a_act_one: assert property (!$past(sys_rst) |->
        in1_active == $past(!in2_selected && !alarm.in1_missing)) else $error("in1 active");
    a_loss_read: assert property (req.rd && req.addr == 8'h81 |=>
        rdata == {5'h00, $past(alarm)}) else $error("loss status read wrong");
    a_sticky_set: assert property (alarm != 3'h0 |=>
        (missing_sticky & $past(alarm)) == $past(alarm)) else $error("sticky flag not set");
    a_sticky_clr: assert property (s_wr(8'h83) ##0 alarm == 3'h0 |=>
        (missing_sticky & ~$past(req.wdata[2:0])) == 3'h0) else $error("sticky flag not cleared");
endmodule
bind idasr_regs idasr_props i_props (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .req            (req),
    .alarm          (alarm),
    .in2_selected   (in2_selected),
    .rdata          (rdata),
    .rvalid         (rvalid),
    .in1_prediv     (in1_prediv),
    .in2_prediv     (in2_prediv),
    .in1_ratio      (in1_ratio),
    .in1_band_sel   (in1_band_sel),
    .in2_band_sel   (in2_band_sel),
    .in1_active     (in1_active),
    .in2_active     (in2_active),
    .missing_sticky (missing_sticky)
);
`default_nettype wire

//--- verification/tb_idasr_regs.sv
// testbench: reset values, dividers, band selects, status and sticky flags
`timescale 1ns/1ps
`default_nettype none
module tb_idasr_regs;
    import idasr_pkg::*;
    logic         clk_sys = 1'b0;
    logic         sys_rst = 1'b1;
    idasr_req_t   req;
    idasr_alarm_t alarm = 3'h0;
    logic         in2_selected = 1'b0;
    logic [7:0]   rdata;
    logic         rvalid;
    logic [19:0]  rt [2];
    logic [7:0]   v;
    logic [7:0]   b;
    logic [2:0]   sticky;
    int           error_cnt = 0;
    int           comparisons = 0;
    logic [15:0]  rst_tab [11] = '{16'h2B00, 16'h2C00, 16'h2D09, 16'h2E00, 16'h2F00, 16'h3000,
                                   16'h3700, 16'h8001, 16'h8100, 16'h8300, 16'h4000};
    logic [11:0]  st_tab [6] = '{12'h010, 12'h202, 12'h820, 12'hC04, 12'h921, 12'h414};
    idasr_regs i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .alarm(alarm),
        .in2_selected(in2_selected), .rdata(rdata), .rvalid(rvalid), .in1_prediv(),
        .in2_prediv(), .in1_ratio(rt[0]), .in2_ratio(rt[1]), .in1_band_sel(),
        .in2_band_sel(), .in1_active(), .in2_active(), .missing_sticky(sticky));
    idasr_host i_host (.clk_sys(clk_sys), .rvalid(rvalid), .rdata(rdata), .req(req));
    // 40 MHz clock
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic check(input string n, input logic [19:0] seen, input logic [19:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, v);
        check($sformatf("reg %h", a), {12'h000, v}, {12'h000, exp});
    endtask
    // every register, both ratios and the sticky pins at their reset values
    task automatic chk_reset;
        foreach (rst_tab[i]) rd_chk(rst_tab[i][15:8], rst_tab[i][7:0]);
        check("ratio1 reset", rt[0], 20'h0000A);
        check("ratio2 reset", rt[1], 20'h00001);
        check("sticky reset", {17'h00000, sticky}, 20'h00000);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // bound on the whole run; the sequence needs under two hundred cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        error_cnt++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        i_host.wr(8'h40, 8'hFF);
        i_host.wr(8'h80, 8'hFF);
        chk_reset();
        // largest and zero codes, reserved upper bits read zero
        for (int k = 0; k < 2; k++) begin
            b = k ? 8'h2E : 8'h2B;
            for (int j = 0; j < 3; j++) i_host.wr(b + j[7:0], 8'hFF);
            rd_chk(b, 8'h07);
            check("ratio max", rt[k], 20'h80000);
            for (int j = 0; j < 3; j++) i_host.wr(b + j[7:0], 8'h00);
            @(posedge clk_sys);
            #1 check("ratio zero", rt[k], 20'h00001);
        end
        // each legal band code once per field, never 110 or 111
        for (int c = 0; c < 6; c++) begin
            i_host.wr(8'h37, {2'b00, 3'(5 - c), 3'(c)});
            rd_chk(8'h37, {2'b00, 3'(5 - c), 3'(c)});
        end
        // selection and alarm combinations
        foreach (st_tab[i]) begin
            @(posedge clk_sys);
            {in2_selected, alarm} <= st_tab[i][11:8];
            rd_chk(8'h80, {4'h0, st_tab[i][7:4]});
            rd_chk(8'h81, {4'h0, st_tab[i][3:0]});
        end
        @(posedge clk_sys);
        alarm <= 3'h0;
        rd_chk(8'h83, 8'h07);
        i_host.wr(8'h83, 8'h00);
        rd_chk(8'h83, 8'h00);
        // alarm held during a clearing write: the set wins
        @(posedge clk_sys);
        alarm <= 3'h2;
        i_host.wr(8'h83, 8'h00);
        rd_chk(8'h83, 8'h02);
        check("sticky pins", {17'h00000, sticky}, 20'h00002);
        // reset in mid-run brings back every reset value
        @(posedge clk_sys);
        alarm <= 3'h0;
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        chk_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
